// File: verilog/qpc_pkg.sv
// register map, field layout and mode codes of the quadrature position counter
package qpc_pkg;

   // register byte addresses
   localparam logic [11:0] CTRL_ADDR = 12'h122; // encoder_control_register
   localparam logic [11:0] FILT_ADDR = 12'h124; // filter_control_register
   localparam logic [11:0] POS_ADDR = 12'h126;  // position_count
   localparam logic [11:0] MAX_ADDR = 12'h128;  // maximum_count

   // encoder_control_register fields
   localparam int CTRL_ERR_BIT = 15;  // count_error_flag
   localparam int CTRL_DIR_BIT = 11;  // count_direction
   localparam int CTRL_MODE_LSB = 8;  // mode_select, three bits
   localparam int CTRL_IDXRES_BIT = 2; // index_reset_enable
   localparam int CTRL_DSRC_BIT = 0;  // direction_source_select

   // filter_control_register fields
   localparam int FILT_IMV_LSB = 9;   // index_match_value, two bits
   localparam int FILT_COUNT_ERROR_IRQ_DISABLE_BIT = 8;  // count_error_irq_disable
   localparam int FILT_OUT_BIT = 7;   // filter_output_enable
   localparam int FILT_DIV_LSB = 4;   // filter_clock_divide, three bits

   // reset values and arithmetic constants
   localparam logic [15:0] POS_RESET = 16'h0000;
   localparam logic [15:0] MAX_RESET = 16'hffff;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   localparam logic [15:0] ONE = 16'h0001;

   // channel positions inside the three-bit input groups
   localparam int CH_A = 0;
   localparam int CH_B = 1;
   localparam int CH_I = 2;

   // filter depth in filter clock samples
   localparam int FILT_DEPTH = 3;

   // mode_select codes
   typedef enum logic [2:0] {
      QPC_OFF = 3'h0,
      QPC_TIMER = 3'h1,
      QPC_X2_IDX = 3'h4,
      QPC_X2_MAX = 3'h5,
      QPC_X4_IDX = 3'h6,
      QPC_X4_MAX = 3'h7
   } qpc_mode_e;

endpackage

// File: verilog/qpc_top.sv
// quadrature position counter with noise filters and alternate timer
`timescale 1ns/1ps

// Notes on behaviour
// - a leading b counts forward
// - 16-bit counter steps one per pulse
// - index modes flag count error at limits
// - error irq disable bit masks error event
// - counting continues after error, no rollover event
// - error flag hardware sets, software clears
// - index reset enable gates index clear
// - index clear needs phase match value
// - x4 match: upper bit b, lower a
// - x2 match: upper selects phase, lower level
// - index modes raise event on index
// - direction drives pin and control bit 11
// - x2 steps on phase a edges only
// - x4 steps on every a or b edge, none when both move at once
// - index or maximum count resets counter
// - filter changes after three stable samples
// - filter clock divided by three-bit field
// - filter output enable, off after reset
// - mode 001 timer clocked by phase a
// - timer period match raises event
// - timer direction from pin b or bit
// - mode change keeps count, synchronous timer
module qpc_top #(
   parameter int FILT_STAGES = qpc_pkg::FILT_DEPTH, // stable samples needed
   parameter int DIV_W = 8                          // filter divider width
) (
   input wire logic clock_i,           // 40 MHz module clock
   input wire logic rst_i,             // asynchronous reset, active high
   input wire logic [11:0] addr_i,     // register byte address
   input wire logic [15:0] wr_data_i,  // write data
   input wire logic wr_i,              // write strobe
   input wire logic rd_i,              // read strobe
   input wire logic phase_a_input_i,   // encoder phase a
   input wire logic phase_b_input_i,   // encoder phase b
   input wire logic index_input_i,     // encoder index
   output logic [15:0] rd_data_o,      // read data, cycle after rd_i
   output logic count_direction_o,     // count direction pin
   output logic event_o                // one-cycle interrupt event
);

   if (FILT_STAGES < 2 || FILT_STAGES > 8 || DIV_W < 8) begin : g_bad_params
      $error("FILT_STAGES outside 2..8 or DIV_W too small for divide by 128");
   end

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // one step of the counter, wrapping naturally
   function automatic logic [15:0] qpc_step(input logic [15:0] v, input logic up);
      qpc_step = up ? v + qpc_pkg::ONE : v - qpc_pkg::ONE;
   endfunction

   // terminal count of the filter divider
   function automatic logic [DIV_W-1:0] qpc_div_lim(input logic [2:0] sel);
      logic [DIV_W:0] p;
      p = (DIV_W + 1)'(1) << sel;
      qpc_div_lim = DIV_W'(p - (DIV_W + 1)'(1));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers and wires

   logic [2:0] mode;
   logic idx_res_en;
   logic dir_src;
   logic dir_q;
   logic cnt_err;
   logic [1:0] imv;
   logic count_error_irq_disable;
   logic flt_out_en;
   logic [2:0] flt_div;
   logic [15:0] pos_cnt;
   logic [15:0] max_cnt;
   logic [15:0] next_pos;

   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] flt;
   logic [2:0] sel;
   logic [2:0] sel_q;
   logic [FILT_STAGES-1:0] hist [3];
   logic [DIV_W-1:0] div_cnt;
   logic flt_en;

   logic wr_ctrl, wr_filt, wr_pos, wr_max;
   logic enc, x4, idx_mode, tmr;
   logic a_edge, b_edge, valid_tr, dec_up;
   logic step_enc, tmr_step, step, step_up;
   logic [15:0] stepped;
   logic at_limit, idx_match, idx_qual, idx_qual_q;
   logic idx_hit, err_hit, next_event;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   assign wr_ctrl = wr_i && addr_i == qpc_pkg::CTRL_ADDR;
   assign wr_filt = wr_i && addr_i == qpc_pkg::FILT_ADDR;
   assign wr_pos = wr_i && addr_i == qpc_pkg::POS_ADDR;
   assign wr_max = wr_i && addr_i == qpc_pkg::MAX_ADDR;

   // control register fields
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         mode <= qpc_pkg::QPC_OFF;
         idx_res_en <= 1'b0;
         dir_src <= 1'b0;
      end else if (wr_ctrl) begin
         mode <= wr_data_i[qpc_pkg::CTRL_MODE_LSB +: 3];
         idx_res_en <= wr_data_i[qpc_pkg::CTRL_IDXRES_BIT];
         dir_src <= wr_data_i[qpc_pkg::CTRL_DSRC_BIT];
      end
   end

   // filter register; reset leaves the filter bypassed
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         imv <= 2'h0;
         count_error_irq_disable <= 1'b0;
         flt_out_en <= 1'b0;
         flt_div <= 3'h0;
      end else if (wr_filt) begin
         imv <= wr_data_i[qpc_pkg::FILT_IMV_LSB +: 2];
         count_error_irq_disable <= wr_data_i[qpc_pkg::FILT_COUNT_ERROR_IRQ_DISABLE_BIT];
         flt_out_en <= wr_data_i[qpc_pkg::FILT_OUT_BIT];
         flt_div <= wr_data_i[qpc_pkg::FILT_DIV_LSB +: 3];
      end
   end

   // period / maximum count register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         max_cnt <= qpc_pkg::MAX_RESET;
      end else if (wr_max) begin
         max_cnt <= wr_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input synchroniser and noise filter

   // two flops per pin; the first is read only by the second
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {index_input_i, phase_b_input_i, phase_a_input_i};
         sync2 <= sync1;
      end
   end

   // filter clock enable, one pulse every 2^divide module clocks
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt <= '0;
      end else if (div_cnt >= qpc_div_lim(flt_div)) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   assign flt_en = div_cnt >= qpc_div_lim(flt_div);

   // output moves only when the whole history agrees
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         for (int c = 0; c < 3; c++) begin
            hist[c] <= '0;
         end
         flt <= 3'h0;
      end else if (flt_en) begin
         for (int c = 0; c < 3; c++) begin
            hist[c] <= {hist[c][FILT_STAGES-2:0], sync2[c]};
            if (&{hist[c][FILT_STAGES-2:0], sync2[c]}) begin
               flt[c] <= 1'b1;
            end else if (~|{hist[c][FILT_STAGES-2:0], sync2[c]}) begin
               flt[c] <= 1'b0;
            end
         end
      end
   end

   // filtered or raw path for all three channels
   assign sel = flt_out_en ? flt : sync2;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sel_q <= 3'h0;
         idx_qual_q <= 1'b0;
      end else begin
         sel_q <= sel;
         idx_qual_q <= idx_qual;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // quadrature decode

   assign enc = mode[2];
   assign x4 = mode[1];
   assign idx_mode = enc && !mode[0];
   assign tmr = mode == qpc_pkg::QPC_TIMER;
   assign a_edge = sel[qpc_pkg::CH_A] ^ sel_q[qpc_pkg::CH_A];
   assign b_edge = sel[qpc_pkg::CH_B] ^ sel_q[qpc_pkg::CH_B];
   // both phases moving at once is a glitch and is dropped
   assign valid_tr = a_edge ^ b_edge;
   assign dec_up = sel_q[qpc_pkg::CH_A] == sel[qpc_pkg::CH_B];
   assign step_enc = enc && valid_tr && (x4 || a_edge);

   // timer counts synchronised rising edges of phase a
   assign tmr_step = tmr && sel[qpc_pkg::CH_A] && !sel_q[qpc_pkg::CH_A];
   assign step = step_enc || tmr_step;
   assign step_up = tmr ? (dir_src ? sel[qpc_pkg::CH_B] : dir_q) : dec_up;
   assign stepped = qpc_step(pos_cnt, step_up);
   assign at_limit = step_up ? pos_cnt == max_cnt : pos_cnt == qpc_pkg::POS_RESET;

   // index match against the phase levels
   always_comb begin
      if (x4) begin
         idx_match = imv == {sel[qpc_pkg::CH_B], sel[qpc_pkg::CH_A]};
      end else begin
         idx_match = (imv[1] ? sel[qpc_pkg::CH_B] : sel[qpc_pkg::CH_A]) == imv[0];
      end
   end

   // only the first cycle of a qualified index counts
   assign idx_qual = idx_mode && sel[qpc_pkg::CH_I] && idx_match;
   assign idx_hit = idx_qual && !idx_qual_q;

   // error only in index modes, at the opposite count limit
   assign err_hit = idx_mode && step && !(idx_hit && idx_res_en) &&
      (step_up ? stepped == max_cnt + qpc_pkg::ONE : stepped == qpc_pkg::ALL_ONES);

   ////////////////////////////////////////////////////////////////////////////
   // position counter

   // a software write wins over a hardware step in the same cycle
   always_comb begin
      next_pos = pos_cnt;
      if (wr_pos) begin
         next_pos = wr_data_i;
      end else if (idx_hit && idx_res_en) begin
         next_pos = qpc_pkg::POS_RESET;
      end else if (step && !idx_mode && at_limit) begin
         next_pos = step_up ? qpc_pkg::POS_RESET : max_cnt;
      end else if (step) begin
         next_pos = stepped;
      end
   end

   // mode writes never touch the count
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pos_cnt <= qpc_pkg::POS_RESET;
      end else begin
         pos_cnt <= next_pos;
      end
   end

   // direction: decoder in encoder modes, pin or bit in timer mode
   // the written bit is judged by the mode being written, so that one write
   // entering timer mode also sets its direction
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         dir_q <= 1'b0;
      end else if (wr_ctrl && wr_data_i[qpc_pkg::CTRL_MODE_LSB +: 3] == qpc_pkg::QPC_TIMER &&
         !wr_data_i[qpc_pkg::CTRL_DSRC_BIT]) begin
         dir_q <= wr_data_i[qpc_pkg::CTRL_DIR_BIT];
      end else if (tmr && dir_src) begin
         dir_q <= sel[qpc_pkg::CH_B];
      end else if (enc && valid_tr) begin
         dir_q <= dec_up;
      end
   end

   assign count_direction_o = dir_q;

   // sticky error flag; a set in the clearing cycle wins
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_err <= 1'b0;
      end else if (err_hit) begin
         cnt_err <= 1'b1;
      end else if (wr_ctrl) begin
         cnt_err <= wr_data_i[qpc_pkg::CTRL_ERR_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event pulse and read port

   // index modes report index and error, never the natural rollover
   assign next_event = idx_hit || (err_hit && !count_error_irq_disable) ||
      (step && !idx_mode && at_limit);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         event_o <= 1'b0;
      end else begin
         event_o <= next_event;
      end
   end

   // unmapped addresses read as zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            qpc_pkg::CTRL_ADDR: begin
               rd_data_o <= {cnt_err, 3'h0, dir_q, mode, 5'h00, idx_res_en, 1'b0,
                  dir_src};
            end
            qpc_pkg::FILT_ADDR: begin
               rd_data_o <= {5'h00, imv, count_error_irq_disable, flt_out_en, flt_div, 4'h0};
            end
            qpc_pkg::POS_ADDR: begin
               rd_data_o <= pos_cnt;
            end
            qpc_pkg::MAX_ADDR: begin
               rd_data_o <= max_cnt;
            end
            default: begin
               rd_data_o <= 16'h0000;
            end
         endcase
      end else begin
         rd_data_o <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   chk_fwd_dir: assert property (
      enc && sel_q[1:0] == 2'b00 && sel[1:0] == 2'b01 |=> dir_q)
      else $error("a leading b did not give forward");

   chk_step_up: assert property (
      step_enc && dec_up && !wr_pos && !idx_hit && mode[0] == 1'b0 && !at_limit
      |=> pos_cnt == $past(pos_cnt) + qpc_pkg::ONE)
      else $error("up step did not add one");

   chk_err_set: assert property (
      err_hit && !wr_pos |=> cnt_err && pos_cnt == $past(stepped))
      else $error("count error not flagged");

   chk_count_error_irq_disable_mask: assert property (
      err_hit && count_error_irq_disable && !idx_hit |=> !event_o)
      else $error("masked count error raised event");

   chk_err_sticky: assert property (
      cnt_err && !wr_ctrl |=> cnt_err)
      else $error("error flag cleared by hardware");

   chk_idx_clear: assert property (
      idx_hit && idx_res_en && !wr_pos |=> pos_cnt == qpc_pkg::POS_RESET ##0 event_o)
      else $error("index did not clear counter");

   chk_x2_b_only: assert property (
      enc && !x4 && b_edge && !a_edge && !wr_pos && !idx_hit |=> $stable(pos_cnt))
      else $error("x2 mode counted a b edge");

   chk_max_wrap: assert property (
      step && mode == qpc_pkg::QPC_X4_MAX && step_up && at_limit && !wr_pos
      |=> pos_cnt == qpc_pkg::POS_RESET && event_o)
      else $error("maximum count did not wrap");

   chk_tmr_down: assert property (
      tmr_step && !step_up && pos_cnt == qpc_pkg::POS_RESET && !wr_pos && !wr_max
      |=> pos_cnt == max_cnt && event_o)
      else $error("timer underflow did not reload period");

   chk_filt_hold: assert property (
      flt_out_en && !flt_en |=> $stable(flt))
      else $error("filter moved between filter clocks");

   chk_mode_keep: assert property (
      wr_ctrl && !step && !wr_pos && !idx_hit |=> $stable(pos_cnt))
      else $error("mode write disturbed count");

   cov_idx_reset: cover property (idx_hit && idx_res_en);
   cov_cnt_err: cover property (err_hit ##1 cnt_err);
   cov_tmr_wrap: cover property (tmr_step && at_limit);
   cov_filt_on: cover property (flt_out_en && flt_en && a_edge);

endmodule

// File: verification/qpc_encoder_model.sv
// behavioural incremental encoder driving the phase and index lines
`timescale 1ns/1ps

module qpc_encoder_model (
   input wire logic clock_i, // module clock, pins move just after its rising edge
   output logic phase_a_o,   // phase a level
   output logic phase_b_o,   // phase b level
   output logic index_o      // index pulse, active high
);
   int q = 0; // quadrature state, (b,a) = 00 01 11 10

   // an encoder powers up at rest in the 00 state
   initial begin
      phase_a_o = 1'b0;
      phase_b_o = 1'b0;
      index_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one quarter step; forward lets phase a lead, gap sets how slow the shaft turns
   task automatic step(input bit fwd, input int gap);
      @(posedge clock_i);
      q = fwd ? (q + 1) % 4 : (q + 3) % 4;
      phase_a_o <= (q == 1 || q == 2);
      phase_b_o <= (q == 2 || q == 3);
      repeat (gap) @(posedge clock_i);
   endtask

   // index pulse while the shaft stands, so the phases hold their match state
   task automatic pulse_index(input int len);
      @(posedge clock_i);
      index_o <= 1'b1;
      repeat (len) @(posedge clock_i);
      index_o <= 1'b0;
   endtask
endmodule

// File: verification/testbench.sv
// self-checking bench for the quadrature position counter
`timescale 1ns/1ps

module testbench;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] addr_i = 12'h000;
   logic [15:0] wr_data_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic pa, pb, idx;
   logic [15:0] rd_data_o;
   logic dir_o;
   logic event_o;
   logic [15:0] ctrl = 16'h0000;
   logic [15:0] lfsr = 16'h8e4a;
   int error_cnt = 0;
   int cmp_count = 0;
   int ev_cnt = 0;
   int exp_pos = 0, exp_max = 65535, exp_ev = 0, mode = 0, q = 0, gap_min = 1;
   bit edir = 1'b0, count_error_irq_disable = 1'b0, err_flag = 1'b0;

   always #12.5 clock_i = ~clock_i;

   qpc_top qpc_top_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .phase_a_input_i(pa),
      .phase_b_input_i(pb), .index_input_i(idx), .rd_data_o(rd_data_o),
      .count_direction_o(dir_o), .event_o(event_o));

   qpc_encoder_model qpc_encoder_model_inst (.clock_i(clock_i), .phase_a_o(pa),
      .phase_b_o(pb), .index_o(idx));

   // count event pulses as the design gives them, one per high cycle
   always @(posedge clock_i) if (event_o === 1'b1) ev_cnt <= ev_cnt + 1;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // bus master: strobes rise after an edge and fall after the next
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so look right then
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 check($sformatf("register %h", a), rd_data_o, exp);
   endtask

   task automatic set_ctrl(input logic [15:0] c);
      wr(qpc_pkg::CTRL_ADDR, c);
      ctrl = c;
      mode = c[10:8];
      err_flag = c[15];
      if (mode == 1) edir = c[0] ? (q == 2 || q == 3) : c[11];
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // reference model of one quarter step, then the same step on the pins
   task automatic do_step(input bit fwd);
      int nq;
      bit a0, a1, b1, cnt, up;
      nq = fwd ? (q + 1) % 4 : (q + 3) % 4;
      a0 = (q == 1 || q == 2);
      a1 = (nq == 1 || nq == 2);
      b1 = (nq == 2 || nq == 3);
      up = (mode == 1) ? (ctrl[0] ? b1 : edir) : fwd;
      cnt = (mode >= 6) || (mode >= 4 && a0 != a1) || (mode == 1 && a1 && !a0);
      if (mode >= 4) edir = fwd;
      if (mode == 1 && ctrl[0]) edir = b1;
      if (cnt && (mode == 4 || mode == 6)) begin
         exp_pos = up ? (exp_pos + 1) % 65536 : (exp_pos + 65535) % 65536;
         if ((up && exp_pos == exp_max + 1) || (!up && exp_pos == 65535)) begin
            err_flag = 1'b1;
            exp_ev += !count_error_irq_disable;
         end
      end else if (cnt) begin
         if (up && exp_pos == exp_max) begin
            exp_pos = 0;
            exp_ev++;
         end else if (!up && exp_pos == 0) begin
            exp_pos = exp_max;
            exp_ev++;
         end else begin
            exp_pos += up ? 1 : -1;
         end
      end
      q = nq;
      lfsr = lfsr_next(lfsr);
      qpc_encoder_model_inst.step(fwd, gap_min + lfsr[1:0]);
   endtask

   // let the pipeline settle, then compare count, control register, direction pin and event count
   task automatic verify();
      repeat (5) @(posedge clock_i);
      rd(qpc_pkg::POS_ADDR, exp_pos[15:0]);
      rd(qpc_pkg::CTRL_ADDR, (ctrl & 16'h0705) | {err_flag, 3'h0, edir, 11'h000});
      check("direction pin", {15'h0000, dir_o}, {15'h0000, edir});
      check("event count", ev_cnt[15:0], exp_ev[15:0]);
   endtask

   task automatic walk(input int n);
      for (int i = 0; i < n; i++) begin
         lfsr = lfsr_next(lfsr);
         do_step(lfsr[0]);
      end
      verify();
   endtask

   task automatic idx_case(input logic [15:0] c, input logic [1:0] imv, input bit hit);
      set_ctrl(c);
      wr(qpc_pkg::FILT_ADDR, {5'h00, imv, 9'h000});
      count_error_irq_disable = 1'b0;
      wr(qpc_pkg::POS_ADDR, 16'h0003);
      exp_pos = (hit && c[2]) ? 0 : 3;
      exp_ev += hit;
      qpc_encoder_model_inst.pulse_index(4);
      verify();
   endtask

   // one step past a limit, then software clears the flag
   task automatic err_case(input int start, input bit fwd, input bit dis);
      wr(qpc_pkg::FILT_ADDR, {7'h00, dis, 8'h00});
      count_error_irq_disable = dis;
      wr(qpc_pkg::POS_ADDR, start[15:0]);
      exp_pos = start;
      do_step(fwd);
      verify();
      set_ctrl(ctrl);
      verify();
   endtask

   task automatic complete_run();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(qpc_pkg::CTRL_ADDR, 16'h0000);
      rd(qpc_pkg::FILT_ADDR, 16'h0000);
      rd(qpc_pkg::POS_ADDR, 16'h0000);
      rd(qpc_pkg::MAX_ADDR, 16'hffff);
      rd(12'h12a, 16'h0000);
      wr(qpc_pkg::MAX_ADDR, 16'h0005);
      exp_max = 5;
      rd(qpc_pkg::MAX_ADDR, 16'h0005);
      set_ctrl(16'h0700);
      walk(24);
      set_ctrl(16'h0500);
      walk(16);
      set_ctrl(16'h0900);
      verify();
      walk(12);
      set_ctrl(16'h0100);
      walk(12);
      set_ctrl(16'h0101);
      walk(12);
      set_ctrl(16'h0700);
      gap_min = 5;
      wr(qpc_pkg::FILT_ADDR, 16'h0080);
      walk(8);
      gap_min = 8;
      wr(qpc_pkg::FILT_ADDR, 16'h0090);
      walk(8);
      gap_min = 1;
      idx_case(16'h0604, {pb, pa}, 1'b1);
      idx_case(16'h0604, {pb, ~pa}, 1'b0);
      idx_case(16'h0600, {pb, pa}, 1'b1);
      idx_case(16'h0404, {1'b1, pb}, 1'b1);
      set_ctrl(16'h0600);
      err_case(0, 1'b0, 1'b0);
      err_case(5, 1'b1, 1'b0);
      err_case(0, 1'b0, 1'b1);
      complete_run();
   end

   // watchdog: the sequence needs under a thousand cycles
   initial begin
      repeat (40000) @(posedge clock_i);
      error_cnt++;
      complete_run();
   end
endmodule
